// file: verilog/dts_core.sv
/*
  DDS tuning and output select core: tuning and offset registers, bank
  selection, phase accumulator, sine or triangle shaping and the square
  output pin. Assumes decoded 16-bit words arrive one per cycle at most
  and that the DAC side may stall through its ready.
*/
`timescale 1ns/10ps

// Behaviour
// - Enable high drives square pin with source
// - Enable low floats the square pin
// - Source high routes comparator to pin
// - Source low routes DAC data MSB
// - Divider bit picks MSB or MSB halved
// - Mode high gives triangle, bypassing sine
// - Mode low gives sine through parabolic approximation
// - Two 28-bit tuning, two 12-bit offsets
// - 28-bit accumulator adds selected word
// - Offset added to top 12 phase bits
// - Select source picks pins or bits
// - Governing selector zero picks first word
// - Governing selector picks phase offset
// - Selection source switchable at any time
// - Bank bits at bit 11 and 10
// - Select source at bit 9
// - Select pins sampled on falling edge
module dts_core (
  // Clock, reset and enable
  input  wire logic                        CLOCK,
  input  wire logic                        RESET_N,
  input  wire logic                        CE,
  // Decoded register words
  input  wire logic                        WORD_VALID,
  input  wire logic [dts_pkg::WORD_W-1:0]  WORD_DATA,
  // Bank select pins and comparator
  input  wire logic                        FREQ_BANK_PIN,
  input  wire logic                        PHASE_BANK_PIN,
  input  wire logic                        COMPARATOR_IN,
  // DAC data stream
  output logic [dts_pkg::DAC_W-1:0]        DAC_DATA,
  output logic                             DAC_VALID,
  input  wire logic                        DAC_READY,
  // Square output pin
  output logic                             SQUARE_OUT,
  output logic                             SQUARE_OUT_EN
);

  logic                         rst_meta;
  logic                         rst_n;
  logic                         pin_freq;
  logic                         pin_phase;
  dts_pkg::dts_state_t          st;
  dts_pkg::dts_state_t          nx;
  logic [1:0]                   cmd;
  logic                         use_b;
  logic                         use_phase_b;
  logic [dts_pkg::ACC_W-1:0]    sel_freq;
  logic [dts_pkg::PHASE_W-1:0]  sel_phase;
  logic [dts_pkg::PHASE_W-1:0]  acc_top;
  logic [dts_pkg::ACC_W-1:0]    fw;
  logic                         hi_half;
  logic                         buf_ready;
  logic                         advance;
  logic [10:0]                  fold;
  logic [dts_pkg::PARA_W-1:0]   para;
  logic [dts_pkg::DAC_W-2:0]    amp;
  logic [dts_pkg::DAC_W-1:0]    sine_word;
  logic [dts_pkg::DAC_W-1:0]    tri_word;
  logic [dts_pkg::DAC_W-1:0]    dac_next;
  logic                         dac_msb;
  logic                         sq_sel;

  // Reset release through two flops
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Pins change near the rising edge, so they are caught half a cycle away
  always_ff @(negedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      pin_freq  <= 1'b0;
      pin_phase <= 1'b0;
    end else if (CE) begin
      pin_freq  <= FREQ_BANK_PIN;
      pin_phase <= PHASE_BANK_PIN;
    end
  end

  // Bank choice follows the governing source in the same cycle
  assign use_b       = st.ctrl.select_source ? pin_freq : st.ctrl.freq_bank_bit;
  assign use_phase_b = st.ctrl.select_source ? pin_phase : st.ctrl.phase_bank_bit;
  assign sel_freq    = use_b ? st.freq_b : st.freq_a;
  assign sel_phase   = use_phase_b ? st.phase_b : st.phase_a;
  assign acc_top     = st.acc[dts_pkg::ACC_W-1:dts_pkg::ACC_TOP_LSB];

  assign cmd     = WORD_DATA[dts_pkg::CMD_MSB:dts_pkg::CMD_LSB];
  assign hi_half = st.ctrl.b28 ? st.lsb_done : st.ctrl.hlb;
  assign fw      = (cmd == dts_pkg::CMD_FREQ_B) ? st.freq_b : st.freq_a;

  // The stream advances only when the buffer can take the word
  assign advance = st.run && buf_ready;

  // Parabolic sine: no table memory, peak error about five percent
  assign fold = st.phase[10:0];
  assign para = dts_pkg::PARA_W'({11'h000, fold} * (dts_pkg::PARA_SPAN - {11'h000, fold}));
  assign amp  = para[20] ? dts_pkg::AMP_MAX : para[19:11];
  assign sine_word = st.phase[11] ? (dts_pkg::DAC_MID - {1'b0, amp})
                                  : (dts_pkg::DAC_MID + {1'b0, amp});
  assign tri_word  = st.phase[11] ? ~st.phase[10:1] : st.phase[10:1];
  assign dac_next  = st.ctrl.wave_mode ? tri_word : sine_word;
  assign dac_msb   = dac_next[dts_pkg::DAC_W-1];

  assign sq_sel = st.ctrl.square_out_source ? COMPARATOR_IN
                : (st.ctrl.msb_divider_select ? dac_msb : st.msb_half);

  always_comb begin
    nx     = st;
    nx.run = 1'b1;
    // Register words; reserved control bits are stored as written
    if (WORD_VALID) begin
      if (cmd == dts_pkg::CMD_CTRL) begin
        nx.ctrl     = dts_pkg::dts_ctrl_t'(WORD_DATA[13:0]);
        nx.lsb_done = 1'b0;
      end else if (cmd == dts_pkg::CMD_PHASE) begin
        if (WORD_DATA[dts_pkg::PHASE_SEL_BIT]) begin
          nx.phase_b = WORD_DATA[dts_pkg::PHASE_W-1:0];
        end else begin
          nx.phase_a = WORD_DATA[dts_pkg::PHASE_W-1:0];
        end
      end else begin
        if (st.ctrl.b28) begin
          nx.lsb_done = ~st.lsb_done;
        end
        if (hi_half) begin
          if (cmd == dts_pkg::CMD_FREQ_B) begin
            nx.freq_b = {WORD_DATA[13:0], fw[13:0]};
          end else begin
            nx.freq_a = {WORD_DATA[13:0], fw[13:0]};
          end
        end else begin
          if (cmd == dts_pkg::CMD_FREQ_B) begin
            nx.freq_b = {fw[27:14], WORD_DATA[13:0]};
          end else begin
            nx.freq_a = {fw[27:14], WORD_DATA[13:0]};
          end
        end
      end
    end
    // Phase path
    if (advance) begin
      nx.acc      = st.acc + sel_freq;
      nx.phase    = acc_top + sel_phase;
      nx.msb_prev = dac_msb;
      if (dac_msb && !st.msb_prev) begin
        nx.msb_half = ~st.msb_half;
      end
    end
    // Square pin
    nx.sq_en  = st.ctrl.square_out_enable;
    nx.sq_out = st.ctrl.square_out_enable ? sq_sel : 1'b0;
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      st <= dts_pkg::ST_RESET;
    end else if (CE) begin
      st <= nx;
    end
  end

  dts_skid u_skid (
    .clk       (CLOCK),
    .rst_n     (rst_n),
    .ce        (CE),
    .in_valid  (st.run),
    .in_data   (dac_next),
    .in_ready  (buf_ready),
    .out_valid (DAC_VALID),
    .out_data  (DAC_DATA),
    .out_ready (DAC_READY)
  );

  assign SQUARE_OUT    = st.sq_out;
  assign SQUARE_OUT_EN = st.sq_en;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!rst_n);

  property p_sq_drive;
    (CE && st.ctrl.square_out_enable) |=> SQUARE_OUT_EN;
  endproperty
  a_sq_drive: assert property (p_sq_drive)
    else $error("square pin not driven while enabled");

  property p_sq_float;
    (CE && !st.ctrl.square_out_enable) |=> (!SQUARE_OUT_EN && !SQUARE_OUT);
  endproperty
  a_sq_float: assert property (p_sq_float)
    else $error("square pin driven while disabled");

  property p_sq_comp;
    (CE && st.ctrl.square_out_enable && st.ctrl.square_out_source)
      |=> SQUARE_OUT == $past(COMPARATOR_IN);
  endproperty
  a_sq_comp: assert property (p_sq_comp)
    else $error("comparator not on square pin");

  property p_sq_msb;
    (CE && st.ctrl.square_out_enable && !st.ctrl.square_out_source
      && st.ctrl.msb_divider_select) |=> SQUARE_OUT == $past(dac_msb);
  endproperty
  a_sq_msb: assert property (p_sq_msb)
    else $error("data MSB not on square pin");

  property p_sq_half;
    (CE && st.ctrl.square_out_enable && !st.ctrl.square_out_source
      && !st.ctrl.msb_divider_select) |=> SQUARE_OUT == $past(st.msb_half);
  endproperty
  a_sq_half: assert property (p_sq_half)
    else $error("halved MSB not on square pin");

  property p_half_toggle;
    (CE && advance && dac_msb && !st.msb_prev) |=> st.msb_half != $past(st.msb_half);
  endproperty
  a_half_toggle: assert property (p_half_toggle)
    else $error("halved MSB missed a rise");

  property p_freq_pin_b;
    (CE && advance && st.ctrl.select_source && pin_freq)
      |=> st.acc == dts_pkg::ACC_W'($past(st.acc) + $past(st.freq_b));
  endproperty
  a_freq_pin_b: assert property (p_freq_pin_b)
    else $error("pin bank one not used");

  property p_freq_bit_a;
    (CE && advance && !st.ctrl.select_source && !st.ctrl.freq_bank_bit)
      |=> st.acc == dts_pkg::ACC_W'($past(st.acc) + $past(st.freq_a));
  endproperty
  a_freq_bit_a: assert property (p_freq_bit_a)
    else $error("bit bank zero not used");

  property p_phase_add;
    (CE && advance && !st.ctrl.select_source && st.ctrl.phase_bank_bit)
      |=> st.phase == dts_pkg::PHASE_W'($past(acc_top) + $past(st.phase_b));
  endproperty
  a_phase_add: assert property (p_phase_add)
    else $error("phase offset one not added");

  property p_tri_zero;
    (st.ctrl.wave_mode && st.phase == 12'h000) |-> dac_next == 10'h000;
  endproperty
  a_tri_zero: assert property (p_tri_zero)
    else $error("triangle not at zero");

  property p_sine_mid;
    (!st.ctrl.wave_mode && st.phase == 12'h000) |-> dac_next == 10'h200;
  endproperty
  a_sine_mid: assert property (p_sine_mid)
    else $error("sine not at midscale");

  property p_freq_hi_write;
    (CE && WORD_VALID && cmd == dts_pkg::CMD_FREQ_B && !st.ctrl.b28 && st.ctrl.hlb)
      |=> st.freq_b[27:14] == $past(WORD_DATA[13:0]);
  endproperty
  a_freq_hi_write: assert property (p_freq_hi_write)
    else $error("tuning word upper half not written");

endmodule

// file: verilog/dts_pkg.sv
/*
  Shared definitions of the DDS tuning and output select core: word codes,
  control word layout, widths, reset values and the state records.
  Assumes a front end that delivers whole decoded 16-bit words.
*/
package dts_pkg;

  // Widths
  localparam int ACC_W        = 28;
  localparam int PHASE_W      = 12;
  localparam int DAC_W        = 10;
  localparam int HALF_W       = 14;
  localparam int WORD_W       = 16;
  localparam int ACC_TOP_LSB  = ACC_W - PHASE_W;

  // Word layout
  localparam int CMD_MSB       = 15;
  localparam int CMD_LSB       = 14;
  localparam int PHASE_SEL_BIT = 13;
  localparam logic [1:0] CMD_CTRL   = 2'h0;
  localparam logic [1:0] CMD_FREQ_A = 2'h1;
  localparam logic [1:0] CMD_FREQ_B = 2'h2;
  localparam logic [1:0] CMD_PHASE  = 2'h3;

  // Amplitude shaping
  localparam int PARA_W     = 22;
  localparam int PARA_SHIFT = 11;
  localparam logic [PARA_W-1:0]  PARA_SPAN = 22'h000800;
  localparam logic [DAC_W-1:0]   DAC_MID   = 10'h200;
  localparam logic [DAC_W-2:0]   AMP_MAX   = 9'h1FF;

  // Control word, bit 13 down to bit 0
  typedef struct packed {
    logic b28;
    logic hlb;
    logic freq_bank_bit;
    logic phase_bank_bit;
    logic select_source;
    logic reset_bit;
    logic sleep_clock;
    logic sleep_dac;
    logic square_out_enable;
    logic square_out_source;
    logic msb_divider_select;
    logic reserved_2;
    logic wave_mode;
    logic reserved_0;
  } dts_ctrl_t;

  typedef struct packed {
    logic [ACC_W-1:0]   freq_a;
    logic [ACC_W-1:0]   freq_b;
    logic [PHASE_W-1:0] phase_a;
    logic [PHASE_W-1:0] phase_b;
    dts_ctrl_t          ctrl;
    logic               lsb_done;
    logic [ACC_W-1:0]   acc;
    logic [PHASE_W-1:0] phase;
    logic               run;
    logic               msb_prev;
    logic               msb_half;
    logic               sq_out;
    logic               sq_en;
  } dts_state_t;

  typedef struct packed {
    logic             main_valid;
    logic             spare_valid;
    logic [DAC_W-1:0] main_data;
    logic [DAC_W-1:0] spare_data;
  } dts_skid_t;

  // Reset values
  localparam dts_state_t ST_RESET   = '0;
  localparam dts_skid_t  SKID_RESET = '0;

endpackage

// file: verilog/dts_skid.sv
/*
  Two-entry buffer between the waveform stage and the DAC port.
  Assumes one clock, an already synchronised active-low reset and a
  clock enable that freezes it.
*/
`timescale 1ns/10ps
module dts_skid (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  // Filling side
  input  wire logic                      in_valid,
  input  wire logic [dts_pkg::DAC_W-1:0] in_data,
  output logic                           in_ready,
  // Draining side
  output logic                           out_valid,
  output logic [dts_pkg::DAC_W-1:0]      out_data,
  input  wire logic                      out_ready
);

  dts_pkg::dts_skid_t st;
  dts_pkg::dts_skid_t nx;

  // Ready is a flop, so the source never sees a combinational path
  assign in_ready  = ~st.spare_valid;
  assign out_valid = st.main_valid;
  assign out_data  = st.main_data;

  always_comb begin
    nx = st;
    if (out_ready || !st.main_valid) begin
      if (st.spare_valid) begin
        nx.main_data   = st.spare_data;
        nx.main_valid  = 1'b1;
        nx.spare_valid = 1'b0;
      end else begin
        nx.main_data  = in_data;
        nx.main_valid = in_valid;
      end
    end else if (in_valid && !st.spare_valid) begin
      nx.spare_data  = in_data;
      nx.spare_valid = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= dts_pkg::SKID_RESET;
    end else if (ce) begin
      st <= nx;
    end
  end

endmodule

// file: tb/dts_host_model.sv
/*
  Host model that loads decoded 16-bit words into the core.
  Assumes the core takes a word at a rising edge with valid high.
*/
`timescale 1ns/10ps
module dts_host_model (
  // Clock
  input  wire logic   clk,
  // Word stream
  output logic        word_valid,
  output logic [15:0] word_data
);
  initial begin
    word_valid = 1'b0;
    word_data  = 16'h0000;
  end
  // One word per call; once released the bus shows the inverse, not a stale copy
  task automatic send(input logic [15:0] w);
    @(posedge clk);
    #1;
    word_valid = 1'b1;
    word_data  = (w[15:14] == 2'h0) ? (w & 16'hFFFA) : w;
    @(posedge clk);
    #1;
    word_valid = 1'b0;
    word_data  = ~word_data;
  endtask
endmodule

// file: tb/dts_core_tb.sv
/*
  Self-checking bench of the DDS core with a host word model.
  Assumes the settled waveform pipeline is shorter than eight cycles.
*/
`timescale 1ns/10ps
module dts_core_tb;
  localparam logic [13:0] B28 = 14'h2000;
  localparam logic [13:0] FB = 14'h0800;
  localparam logic [13:0] PB = 14'h0400;
  localparam logic [13:0] SS = 14'h0200;
  localparam logic [13:0] EN = 14'h0020;
  localparam logic [13:0] SRC = 14'h0010;
  localparam logic [13:0] DIV = 14'h0008;
  localparam logic [13:0] MODE = 14'h0002;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        fpin = 1'b0;
  logic        ppin = 1'b0;
  logic        comp = 1'b0;
  logic        ready = 1'b1;
  logic        word_valid;
  logic [15:0] word_data;
  logic [9:0]  dac_data;
  logic        dac_valid;
  logic        sq;
  logic        sq_en;
  logic [13:0] cur = 14'h0000;
  wire         pin;
  int          miscompares = 0;
  int          checks = 0;

  always #2.5 clock = ~clock;
  // Pin resolved from the enable, so a float shows as Z
  assign pin = sq_en ? sq : 1'bz;

  dts_host_model host (.clk(clock), .word_valid(word_valid), .word_data(word_data));
  dts_core uut (.CLOCK(clock), .RESET_N(reset_n), .CE(1'b1), .WORD_VALID(word_valid),
    .WORD_DATA(word_data), .FREQ_BANK_PIN(fpin), .PHASE_BANK_PIN(ppin),
    .COMPARATOR_IN(comp), .DAC_DATA(dac_data), .DAC_VALID(dac_valid),
    .DAC_READY(ready), .SQUARE_OUT(sq), .SQUARE_OUT_EN(sq_en));

  task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [9:0] tri_of(input logic [11:0] p);
    return p[11] ? ~p[10:1] : p[10:1];
  endfunction

  task automatic ctrl(input logic [13:0] b);
    cur = b;
    host.send({dts_pkg::CMD_CTRL, b | B28});
  endtask

  // Control write first clears the half flag, then low and high halves
  task automatic wr_freq(input logic [1:0] cmd, input logic [27:0] v);
    ctrl(cur);
    host.send({cmd, v[13:0]});
    host.send({cmd, v[27:14]});
  endtask

  task automatic wr_phase(input logic b, input logic [11:0] v);
    host.send({dts_pkg::CMD_PHASE, b, 1'b0, v});
  endtask

  task automatic settle();
    repeat (8) @(posedge clock);
    #1;
  endtask

  task automatic set_pins(input logic f, input logic p);
    @(posedge clock);
    #1;
    fpin = f;
    ppin = p;
    settle();
  endtask

  task automatic take(output logic [9:0] w);
    for (int n = 0; n < 20; n++) begin
      @(posedge clock);
      if (dac_valid === 1'b1 && ready === 1'b1) begin
        w = dac_data;
        break;
      end
    end
  endtask

  task automatic rises(output int r);
    logic prev;
    r = 0;
    prev = sq;
    repeat (256) begin
      @(posedge clock);
      #1;
      if (sq === 1'b1 && prev === 1'b0) r++;
      prev = sq;
    end
  endtask

  task automatic t_reset();
    settle();
    check_val("square_en", 16'h0, sq_en);
    check_val("dac_valid", 16'h1, dac_valid);
    check_val("dac_mid", 16'h200, dac_data);
    $display("test reset done");
  endtask

  task automatic t_phase();
    wr_phase(1'b0, 12'h100);
    wr_phase(1'b1, 12'h300);
    ctrl(MODE);
    settle();
    check_val("tri_a", tri_of(12'h100), dac_data);
    ctrl(MODE | PB);
    settle();
    check_val("tri_b", tri_of(12'h300), dac_data);
    wr_phase(1'b0, 12'hC00);
    wr_phase(1'b1, 12'h400);
    ctrl(PB);
    settle();
    check_val("sine_peak", 16'h3FF, dac_data);
    ctrl(14'h0000);
    settle();
    check_val("sine_low", 16'h001, dac_data);
    $display("test phase done");
  endtask

  task automatic t_pins();
    ctrl(SS | MODE | PB);
    settle();
    check_val("pin_gov", tri_of(12'hC00), dac_data);
    set_pins(1'b0, 1'b1);
    check_val("pin_b", tri_of(12'h400), dac_data);
    ctrl(MODE);
    settle();
    check_val("bits_back", tri_of(12'hC00), dac_data);
    $display("test pins done");
  endtask

  // Word B steps the phase by 2, so the triangle rises by 1 per word
  task automatic t_freq();
    logic [9:0] w0;
    logic [9:0] w1;
    wr_freq(dts_pkg::CMD_FREQ_B, 28'h0020000);
    ctrl(SS | MODE);
    settle();
    set_pins(1'b1, 1'b1);
    take(w0);
    for (int i = 1; i < 11; i++) begin
      take(w1);
      check_val("step", w0 + 10'h001, w1);
      w0 = w1;
      if (i == 5) begin
        #1;
        ready = 1'b0;
        repeat (4) @(posedge clock);
        #1;
        check_val("stall_hold", w0 + 10'h001, dac_data);
        check_val("stall_valid", 16'h1, dac_valid);
        ready = 1'b1;
      end
    end
    set_pins(1'b0, 1'b1);
    w0 = dac_data;
    repeat (5) @(posedge clock);
    #1;
    check_val("freeze", w0, dac_data);
    $display("test freq done");
  endtask

  task automatic t_square();
    int r;
    ctrl(EN | SRC);
    @(posedge clock);
    #1;
    comp = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    check_val("cmp_hi", 16'h1, pin);
    comp = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    check_val("cmp_lo", 16'h0, pin);
    ctrl(EN | DIV);
    settle();
    check_val("msb_lo", 16'h0, pin);
    ctrl(EN | DIV | PB);
    settle();
    check_val("msb_hi", 16'h1, pin);
    wr_freq(dts_pkg::CMD_FREQ_B, 28'h1000000);
    ctrl(EN | DIV | FB);
    settle();
    rises(r);
    check_val("rise_full", 16'h1, r >= 15 && r <= 17);
    ctrl(EN | FB);
    settle();
    rises(r);
    check_val("rise_half", 16'h1, r >= 7 && r <= 9);
    ctrl(14'h0000);
    settle();
    check_val("pin_float", 1'bz, pin);
    $display("test square done");
  endtask

  // Split mode: high half of word B alone, zero, freezes the phase
  task automatic t_halves();
    logic [9:0] w0;
    host.send({dts_pkg::CMD_CTRL, 14'h1000 | FB | MODE});
    host.send({dts_pkg::CMD_FREQ_B, 14'h0000});
    settle();
    w0 = dac_data;
    repeat (5) @(posedge clock);
    #1;
    check_val("half_freeze", w0, dac_data);
    $display("test halves done");
  endtask

  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clock);
    #1;
    reset_n = 1'b1;
    repeat (4) @(posedge clock);
    t_reset();
    t_phase();
    t_pins();
    t_freq();
    t_square();
    t_halves();
    complete_run();
  end

  // Tests take about 800 cycles; the limit leaves wide margin
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end
endmodule
